// *** include/iobd_defs.vh ***
`ifndef IOBD_DEFS_VH
`define IOBD_DEFS_VH

// window geometry
`define IOBD_WINDOW_SIZE 16
`define IOBD_A9_BIT 9
`define IOBD_SW_HI 8
`define IOBD_SW_LO 4
`define IOBD_SW_WIDTH 5
// factory switch word, 1 = position on; on means address bit 0
// base 0x220 -> A8..A4 = 00010 -> on,on,on,off,on
`define IOBD_SW_DEFAULT 5'h1d
// wide-port offsets inside the window
`define IOBD_OFS_AD_DATA 4'h4
`define IOBD_OFS_AD_FIFO 4'h6
`define IOBD_OFS_DIO 4'he

`endif

// *** core/iobd_decoder.v ***
// Notes on behaviour
// - claim sixteen consecutive addresses, A3..A0 select
// - respond only within 0x200 to 0x3ff
// - A9 must be one, base aligned 16
// - switch positions map onto A8..A4
// - switch on means zero, off means one
// - factory switch setting gives base 0x220
// - data, fifo, dio ports need 16-bit cycles
`timescale 1ns/1ps
`include "iobd_defs.vh"

module iobd_decoder (
    input wire core_clk,
    input wire reset_n,
    input wire [15:0] bus_addr,
    input wire bus_ior_n,
    input wire bus_iow_n,
    input wire bus_aen,
    input wire [4:0] base_select_switch,
    output reg card_select,
    output reg read_strobe,
    output reg write_strobe,
    output reg [3:0] reg_index,
    output reg wide_port,
    output reg io16_n
);

// ----------------------------------------
// helpers
// ----------------------------------------
// switch on (1) expects a zero address bit
function [4:0] sw_to_addr;
    input [4:0] sw;
    begin
        sw_to_addr = ~sw;
    end
endfunction

// two-byte ports: analog data, fifo data, dio
function is_wide;
    input [3:0] ofs;
    begin
        is_wide = ({ofs[3:1], 1'b0} == `IOBD_OFS_AD_DATA) ||
            ({ofs[3:1], 1'b0} == `IOBD_OFS_AD_FIFO) ||
            ({ofs[3:1], 1'b0} == `IOBD_OFS_DIO);
    end
endfunction

// upper address against the switch-derived base
function window_hit;
    input [15:0] addr;
    input [4:0] sw;
    reg a9_ok;
    reg hi_zero;
    reg sw_ok;
    begin
        a9_ok = addr[`IOBD_A9_BIT];
        hi_zero = (addr[15:10] == 6'h00);
        sw_ok = (addr[`IOBD_SW_HI:`IOBD_SW_LO] == sw_to_addr(sw));
        window_hit = a9_ok && hi_zero && sw_ok;
    end
endfunction

// ----------------------------------------
// pin synchroniser registers
// ----------------------------------------
reg [15:0] addr_s1;
reg [15:0] addr_s2;
reg [15:0] addr_s3;
reg [15:0] addr_q;
reg [2:0] ctl_s1;
reg [2:0] ctl_s2;
reg [2:0] ctl_s3;
reg [2:0] ctl_q;
reg [4:0] sw_s1;
reg [4:0] sw_s2;
reg [4:0] sw_s3;
reg [4:0] sw_q;

// ----------------------------------------
// address pins, three stages
// ----------------------------------------
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        addr_s1 <= 16'h0000;
        addr_s2 <= 16'h0000;
        addr_s3 <= 16'h0000;
    end else begin
        addr_s1 <= bus_addr;
        addr_s2 <= addr_s1;
        addr_s3 <= addr_s2;
    end
end

// a new address counts once stages two and three agree
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        addr_q <= 16'h0000;
    end else if (addr_s2 == addr_s3) begin
        addr_q <= addr_s3;
    end
end

// ----------------------------------------
// command pins, three stages
// ----------------------------------------
// bit 2 aen, bit 1 write low, bit 0 read low
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        ctl_s1 <= 3'h7;
        ctl_s2 <= 3'h7;
        ctl_s3 <= 3'h7;
    end else begin
        ctl_s1 <= {bus_aen, bus_iow_n, bus_ior_n};
        ctl_s2 <= ctl_s1;
        ctl_s3 <= ctl_s2;
    end
end

always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        ctl_q <= 3'h7;
    end else if (ctl_s2 == ctl_s3) begin
        ctl_q <= ctl_s3;
    end
end

// ----------------------------------------
// switch pins, three stages
// ----------------------------------------
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        sw_s1 <= `IOBD_SW_DEFAULT;
        sw_s2 <= `IOBD_SW_DEFAULT;
        sw_s3 <= `IOBD_SW_DEFAULT;
    end else begin
        sw_s1 <= base_select_switch;
        sw_s2 <= sw_s1;
        sw_s3 <= sw_s2;
    end
end

// factory base until the switch is first sampled
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        sw_q <= `IOBD_SW_DEFAULT;
    end else if (sw_s2 == sw_s3) begin
        sw_q <= sw_s3;
    end
end

// ----------------------------------------
// address match
// ----------------------------------------
wire hit;
wire io_rd;
wire io_wr;

assign hit = window_hit(addr_q, sw_q);
// aen high marks a dma cycle, not a host io cycle
assign io_rd = !ctl_q[0] && !ctl_q[2];
assign io_wr = !ctl_q[1] && !ctl_q[2];

// ----------------------------------------
// next output values
// ----------------------------------------
reg next_sel;
reg next_rd;
reg next_wr;
reg [3:0] next_index;
reg next_wide;
reg next_io16_n;

always @* begin
    next_sel = hit && (io_rd || io_wr);
    next_rd = next_sel && io_rd;
    next_wr = next_sel && io_wr;
    next_index = addr_q[3:0];
    next_wide = hit && is_wide(addr_q[3:0]);
    next_io16_n = !next_wide;
end

// ----------------------------------------
// select and strobe outputs
// ----------------------------------------
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        card_select <= 1'b0;
        read_strobe <= 1'b0;
        write_strobe <= 1'b0;
    end else begin
        card_select <= next_sel;
        read_strobe <= next_rd;
        write_strobe <= next_wr;
    end
end

// ----------------------------------------
// index and port width outputs
// ----------------------------------------
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        reg_index <= 4'h0;
        wide_port <= 1'b0;
        io16_n <= 1'b1;
    end else begin
        reg_index <= next_index;
        wide_port <= next_wide;
        io16_n <= next_io16_n;
    end
end

endmodule

// *** dv/iobd_host_model.sv ***
`timescale 1ns/1ps
module iobd_host_model (
    input wire core_clk,
    output reg [15:0] bus_addr,
    output reg bus_ior_n,
    output reg bus_iow_n,
    output reg bus_aen
);
    initial {bus_addr, bus_ior_n, bus_iow_n, bus_aen} = 19'h7fffe;
    // k[1] read, k[0] write; held long enough for the input filter
    task io(input [15:0] a, input [1:0] k, input e);
        @(posedge core_clk) #1;
        {bus_addr, bus_ior_n, bus_iow_n, bus_aen} = {a, ~k, e};
        repeat (8) @(posedge core_clk);
        #1;
    endtask
endmodule

// *** dv/iobd_decoder_asserts.sv ***
`timescale 1ns/1ps
module iobd_decoder_asserts (input wire core_clk, reset_n, bus_ior_n,
    bus_iow_n, bus_aen, card_select, read_strobe, write_strobe, wide_port,
    io16_n, input wire [15:0] bus_addr, input wire [4:0] base_select_switch,
    input wire [3:0] reg_index);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire hit = bus_addr[15:4] == {7'h01, ~base_select_switch} && !bus_aen;
    wire rd = hit && !bus_ior_n;
    wire wr = hit && !bus_iow_n;
    wire wide = bus_addr[3:2] == 2'h1 || bus_addr[3:1] == 3'h7;
    sequence st;
        $stable({bus_addr, bus_ior_n, bus_iow_n, bus_aen,
            base_select_switch})[*7];
    endsequence
    a_sel_match: assert property (st |-> card_select == (rd || wr))
        else $error("select wrong");
    a_rd_strobe: assert property (st |-> read_strobe == rd)
        else $error("read strobe wrong");
    a_wr_strobe: assert property (st |-> write_strobe == wr)
        else $error("write strobe wrong");
    a_index_sync: assert property (st |-> reg_index == bus_addr[3:0])
        else $error("index wrong");
    a_wide_port: assert property (
        st ##0 (rd || wr) |-> wide_port == wide)
        else $error("wide flag wrong");
    a_wide_io16: assert property (wide_port |-> !io16_n)
        else $error("io16 not low");
    a_strobe_sel: assert property (
        read_strobe || write_strobe |-> card_select)
        else $error("strobe without select");
    a_idle_quiet: assert property (
        (bus_ior_n && bus_iow_n)[*6] |-> !card_select)
        else $error("select while idle");
    cover property (read_strobe && wide_port);
    cover property (write_strobe);
    cover property ($fell(card_select));
endmodule
bind iobd_decoder iobd_decoder_asserts u_iobd_decoder_asserts (.*);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    reg core_clk = 0, reset_n = 0;
    reg [4:0] sw = 5'h1d;
    wire [15:0] a;
    wire [3:0] ix;
    wire ior_n, iow_n, aen, cs, rs, ws, wp, w16;
    integer failures = 0, checks = 0, s, o;
    reg wd;
    always #2.5 core_clk = ~core_clk;
    iobd_host_model u_iobd_host_model (.core_clk(core_clk), .bus_addr(a),
        .bus_ior_n(ior_n), .bus_iow_n(iow_n), .bus_aen(aen));
    iobd_decoder u_iobd_decoder (.core_clk(core_clk), .reset_n(reset_n),
        .bus_addr(a), .bus_ior_n(ior_n), .bus_iow_n(iow_n), .bus_aen(aen),
        .base_select_switch(sw), .card_select(cs), .read_strobe(rs),
        .write_strobe(ws), .reg_index(ix), .wide_port(wp), .io16_n(w16));
    task chk(input [63:0] n, input [7:0] v, input [7:0] e);
        checks = checks + 1;
        if (v !== e) begin
            failures = failures + 1;
            $display("ERROR %0s exp %h seen %h", n, e, v);
        end
    endtask
    task t_factory;
        for (o = 0; o < 16; o = o + 1) begin
            u_iobd_host_model.io(16'h220 | o, 2'h2, 0);
            wd = o[3:2] == 1 || o[3:1] == 7;
            chk("factory", {cs, rs, ws, wp, ix}, {3'h6, wd,
                o[3:0]});
            chk("io16", {7'h00, w16}, {7'h00, !wd});
        end
    endtask
    task t_sweep;
        for (s = 0; s < 32; s = s + 1) begin
            sw = s[4:0];
            u_iobd_host_model.io({7'h01, ~s[4:0], 4'h9}, 2'h1, 0);
            chk("base", {cs, rs, ws, wp, ix}, 8'ha9);
            u_iobd_host_model.io({7'h40, ~s[4:0], 4'h9}, 2'h1, 0);
            chk("span", {cs, rs, ws, wp, ix}, 8'h09);
            u_iobd_host_model.io({7'h01, s[4:0], 4'h9}, 2'h2, 0);
            chk("mismatch", {cs, rs, ws, wp, ix}, 8'h09);
            u_iobd_host_model.io({7'h01, ~s[4:0], 4'h9}, 2'h2, 1);
            chk("dma", {cs, rs, ws, wp, ix}, 8'h09);
        end
    endtask
    task finish_test;
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1 reset_n = 1;
        t_factory;
        t_sweep;
        finish_test;
    end
endmodule
